// >>> rtl/dma_channel_control.sv
`timescale 1ns/1ps
module dma_channel_control import dmach_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic [EXT_CH-1:0] I_HANDSHAKE_REQ_IN_N,
  input wire logic [MOD_N-1:0] I_MOD_REQ_N,
  input wire logic I_NMI,
  input wire logic I_ADDR_ERR,
  output logic [EXT_CH-1:0] O_HANDSHAKE_ACK_OUT,
  output logic [NCH-1:0] O_END_IRQ,
  output logic O_BUS_REQ,
  output logic O_BUS_WRITE,
  output logic [31:0] O_BUS_ADDR,
  output logic [1:0] O_BUS_SIZE,
  output logic [1:0] O_BUS_CH,
  output logic O_BUS_HOLD,
  input wire logic I_BUS_ACK,
  input wire logic [31:0] I_BUS_RDATA
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_ff [NCH];
  logic [CNT_W-1:0] cnt_ff [NCH];
  logic [31:0] src_ff [NCH];
  logic [31:0] dst_ff [NCH];
  logic [31:0] src_nx [NCH];
  logic [31:0] dst_nx [NCH];
  logic [31:0] ctrl_rd [NCH];
  logic [NCH-1:0] te_ff, te_seen_ff, pend_ff, en_vec, req_vec, start_vec;
  logic [NCH-1:0] ext_v, smd_v, sdm_v, ptr_v, tm_v, big_v, edge_v, pin_low, pin_fall;
  logic [NCH-1:0] wr_ctrl, wr_cnt, wr_src, wr_dst, rd_ctrl, done_v, launch_v;
  logic [EXT_CH-1:0] ext_prev_ff, ack_act;
  logic [MOD_N-1:0] mod_prev_ff, mod_fall;
  logic dme_ff, nmi_halt_flag_ff, ae_ff, nmi_halt_flag_seen_ff, ae_seen_ff, glob_ok;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff, wr_fire, ar_fire, wr_map, rd_map;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, be, rd_val, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff, wr_ch, rd_ch, wr_reg, rd_reg;
  logic wr_glob, rd_glob;
  xfer_st_t state_ff, nxt_state;
  logic [1:0] cur_ch_ff, nxt_ch, beat_ff, nxt_beat, low_ch, pick_ch;
  logic [31:0] addr_ff, nxt_addr, ptr_data_ff, ptr_val, beat_ofs;
  logic hold_ff, unit_done, start_any, last_beat;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [31:0] m);
    merge = (o & ~m) | (n & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register bus slave
  assign O_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
  assign O_AXI_WREADY = !w_got_ff && !bvalid_ff;
  assign O_AXI_ARREADY = !rvalid_ff;
  assign O_AXI_BVALID = bvalid_ff;
  assign O_AXI_BRESP = bresp_ff;
  assign O_AXI_RVALID = rvalid_ff;
  assign O_AXI_RDATA = rdata_ff;
  assign O_AXI_RRESP = rresp_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign ar_fire = I_AXI_ARVALID && !rvalid_ff;
  assign wr_ch = awaddr_ff[CH_LSB+:2];
  assign wr_reg = awaddr_ff[REG_LSB+:2];
  assign wr_glob = {awaddr_ff[7:REG_LSB], 2'b00} == OFS_GLOBAL;
  assign wr_map = wr_glob || awaddr_ff < OFS_GLOBAL;
  assign rd_ch = I_AXI_ARADDR[CH_LSB+:2];
  assign rd_reg = I_AXI_ARADDR[REG_LSB+:2];
  assign rd_glob = {I_AXI_ARADDR[7:REG_LSB], 2'b00} == OFS_GLOBAL;
  assign rd_map = rd_glob || I_AXI_ARADDR < OFS_GLOBAL;
  assign glob_ok = dme_ff && !nmi_halt_flag_ff && !ae_ff;

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      be <= 32'h00000000;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= I_AXI_WDATA;
        be <= {{8{I_AXI_WSTRB[3]}}, {8{I_AXI_WSTRB[2]}}, {8{I_AXI_WSTRB[1]}},
               {8{I_AXI_WSTRB[0]}}};
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? RESP_OK : RESP_SLVERR;
      end else if (I_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    case (rd_reg)
      OFS_CTRL[REG_LSB+:2]: rd_val = ctrl_rd[rd_ch];
      OFS_CNT[REG_LSB+:2]: rd_val = {{(32-CNT_W){1'b0}}, cnt_ff[rd_ch]};
      OFS_SRC[REG_LSB+:2]: rd_val = src_ff[rd_ch];
      default: rd_val = dst_ff[rd_ch];
    endcase
    if (rd_glob) begin
      rd_val = 32'h00000000;
      rd_val[G_DME] = dme_ff;
      rd_val[G_NMI_HALT_FLAG] = nmi_halt_flag_ff;
      rd_val[G_AE] = ae_ff;
    end else if (!rd_map) begin
      rd_val = 32'h00000000;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OK;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_map ? RESP_OK : RESP_SLVERR;
    end else if (I_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // global enable and error flags, set wins over clear
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      dme_ff <= 1'b0;
      nmi_halt_flag_ff <= 1'b0;
      ae_ff <= 1'b0;
      nmi_halt_flag_seen_ff <= 1'b0;
      ae_seen_ff <= 1'b0;
      ext_prev_ff <= '1;
      mod_prev_ff <= '1;
    end else begin
      if (wr_fire && wr_glob && be[G_DME]) dme_ff <= wdata_ff[G_DME];
      if (I_NMI) begin
        nmi_halt_flag_ff <= 1'b1;
      end else if (wr_fire && wr_glob && be[G_NMI_HALT_FLAG] && !wdata_ff[G_NMI_HALT_FLAG] && nmi_halt_flag_seen_ff) begin
        nmi_halt_flag_ff <= 1'b0;
      end
      if (I_ADDR_ERR) begin
        ae_ff <= 1'b1;
      end else if (wr_fire && wr_glob && be[G_AE] && !wdata_ff[G_AE] && ae_seen_ff) begin
        ae_ff <= 1'b0;
      end
      nmi_halt_flag_seen_ff <= nmi_halt_flag_ff && (nmi_halt_flag_seen_ff || (ar_fire && rd_glob)) && !wr_fire;
      ae_seen_ff <= ae_ff && (ae_seen_ff || (ar_fire && rd_glob)) && !wr_fire;
      ext_prev_ff <= I_HANDSHAKE_REQ_IN_N;
      mod_prev_ff <= I_MOD_REQ_N;
    end
  end

  assign mod_fall = mod_prev_ff & ~I_MOD_REQ_N;

  ////////////////////////////////////////////////////////////////////////////////
  // per channel control
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      localparam logic [31:0] MSK = (g < EXT_CH) ? MASK_EXT : (g == DI_CH) ? MASK_DI : MASK_BASE;
      logic [3:0] rs;
      logic mod_sel, legal, src_ok, dst_ok;
      logic [1:0] ts;
      assign rs = ctrl_ff[g][B_RS+:4];
      assign ts = ctrl_ff[g][B_TS+:2];
      assign ext_v[g] = (g < EXT_CH) && (rs == RS_EXT_DUAL || smd_v[g] || sdm_v[g]);
      assign smd_v[g] = (g < EXT_CH) && rs == RS_EXT_S_MD;
      assign sdm_v[g] = (g < EXT_CH) && rs == RS_EXT_S_DM;
      assign mod_sel = rs >= RS_MOD_LO;
      assign legal = ext_v[g] || rs == RS_AUTO || mod_sel;
      assign ptr_v[g] = ctrl_ff[g][B_DI];
      assign tm_v[g] = ctrl_ff[g][B_TM];
      assign big_v[g] = ts == SIZE_16B;
      if (g < EXT_CH) begin : gpin
        assign pin_low[g] = !I_HANDSHAKE_REQ_IN_N[g];
        assign pin_fall[g] = ext_prev_ff[g] && !I_HANDSHAKE_REQ_IN_N[g];
      end else begin : gnopin
        assign pin_low[g] = 1'b0;
        assign pin_fall[g] = 1'b0;
      end
      assign edge_v[g] = mod_sel ? mod_fall[3'(rs - RS_MOD_LO)] :
                         (ext_v[g] && ctrl_ff[g][B_DS] && pin_fall[g]);
      assign req_vec[g] = rs == RS_AUTO || pend_ff[g] ||
                          (ext_v[g] && !ctrl_ff[g][B_DS] && pin_low[g]);
      assign en_vec[g] = ctrl_ff[g][B_DE] && !te_ff[g] && glob_ok && legal &&
                         src_ok && dst_ok;
      assign start_vec[g] = en_vec[g] && req_vec[g];
      assign wr_ctrl[g] = wr_fire && !wr_glob && wr_map && wr_ch == g && wr_reg == OFS_CTRL[3:2];
      assign wr_cnt[g] = wr_fire && !wr_glob && wr_map && wr_ch == g && wr_reg == OFS_CNT[3:2];
      assign wr_src[g] = wr_fire && !wr_glob && wr_map && wr_ch == g && wr_reg == OFS_SRC[3:2];
      assign wr_dst[g] = wr_fire && !wr_glob && wr_map && wr_ch == g && wr_reg == OFS_DST[3:2];
      assign rd_ctrl[g] = ar_fire && !rd_glob && rd_map && rd_ch == g && rd_reg == OFS_CTRL[3:2];
      assign done_v[g] = unit_done && cur_ch_ff == g;
      assign launch_v[g] = state_ff == ST_IDLE && start_any && pick_ch == g;
      assign ctrl_rd[g] = ctrl_ff[g] | ({31'h0, te_ff[g]} << B_TE);
      assign O_END_IRQ[g] = te_ff[g] && ctrl_ff[g][B_IE];
      dmach_step u_src (
        .i_addr(src_ff[g]),
        .i_mode(ctrl_ff[g][B_SM+:2]),
        .i_size(ts),
        .i_ptr(ptr_v[g]),
        .o_next(src_nx[g]),
        .o_legal(src_ok)
      );
      dmach_step u_dst (
        .i_addr(dst_ff[g]),
        .i_mode(ctrl_ff[g][B_DM+:2]),
        .i_size(ts),
        .i_ptr(1'b0),
        .o_next(dst_nx[g]),
        .o_legal(dst_ok)
      );
      always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
          ctrl_ff[g] <= 32'h00000000;
          te_ff[g] <= 1'b0;
          te_seen_ff[g] <= 1'b0;
          pend_ff[g] <= 1'b0;
          cnt_ff[g] <= '0;
          src_ff[g] <= 32'h00000000;
          dst_ff[g] <= 32'h00000000;
        end else begin
          if (wr_ctrl[g]) ctrl_ff[g] <= merge(ctrl_ff[g], wdata_ff, be) & MSK;
          if (done_v[g] && cnt_ff[g] == CNT_ONE) begin
            te_ff[g] <= 1'b1;
          end else if (wr_ctrl[g] && be[B_TE] && !wdata_ff[B_TE] && te_seen_ff[g]) begin
            te_ff[g] <= 1'b0;
          end
          te_seen_ff[g] <= te_ff[g] && (te_seen_ff[g] || rd_ctrl[g]) && !wr_ctrl[g];
          if (!en_vec[g]) pend_ff[g] <= 1'b0;
          else if (edge_v[g]) pend_ff[g] <= 1'b1;
          else if (launch_v[g]) pend_ff[g] <= 1'b0;
          if (wr_cnt[g]) cnt_ff[g] <= CNT_W'(merge(32'(cnt_ff[g]), wdata_ff, be));
          else if (done_v[g]) cnt_ff[g] <= cnt_ff[g] - CNT_ONE;
          if (wr_src[g]) src_ff[g] <= merge(src_ff[g], wdata_ff, be);
          else if (done_v[g]) src_ff[g] <= src_nx[g];
          if (wr_dst[g]) dst_ff[g] <= merge(dst_ff[g], wdata_ff, be);
          else if (done_v[g]) dst_ff[g] <= dst_nx[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb begin
    low_ch = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (start_vec[i]) low_ch = 2'(i);
    end
  end

  assign start_any = |start_vec;
  assign pick_ch = (hold_ff && start_vec[cur_ch_ff]) ? cur_ch_ff : low_ch;
  assign last_beat = !big_v[cur_ch_ff] || beat_ff == LAST_BEAT;
  assign ptr_val = (state_ff == ST_PTR) ? I_BUS_RDATA : ptr_data_ff;
  assign beat_ofs = 32'(nxt_beat) * LW_BYTES;

  always_comb begin
    nxt_state = state_ff;
    nxt_ch = cur_ch_ff;
    nxt_beat = beat_ff;
    unit_done = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_any) begin
          nxt_ch = pick_ch;
          nxt_beat = 2'h0;
          nxt_state = ptr_v[pick_ch] ? ST_PTR : sdm_v[pick_ch] ? ST_WR : ST_RD;
        end
      end
      ST_PTR: begin
        if (!en_vec[cur_ch_ff]) nxt_state = ST_IDLE;
        else if (I_BUS_ACK) nxt_state = ST_RD;
      end
      ST_RD: begin
        if (!en_vec[cur_ch_ff]) begin
          nxt_state = ST_IDLE;
        end else if (I_BUS_ACK && !smd_v[cur_ch_ff]) begin
          nxt_state = ST_WR;
        end else if (I_BUS_ACK && last_beat) begin
          unit_done = 1'b1;
          nxt_state = ST_IDLE;
        end else if (I_BUS_ACK) begin
          nxt_beat = beat_ff + 2'h1;
        end
      end
      ST_WR: begin
        if (!en_vec[cur_ch_ff]) begin
          nxt_state = ST_IDLE;
        end else if (I_BUS_ACK && last_beat) begin
          unit_done = 1'b1;
          nxt_state = ST_IDLE;
        end else if (I_BUS_ACK) begin
          nxt_beat = beat_ff + 2'h1;
          nxt_state = sdm_v[cur_ch_ff] ? ST_WR : ST_RD;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_comb begin
    case (nxt_state)
      ST_PTR: nxt_addr = src_ff[nxt_ch];
      ST_RD: nxt_addr = ptr_v[nxt_ch] ? ptr_val : src_ff[nxt_ch] + beat_ofs;
      ST_WR: nxt_addr = dst_ff[nxt_ch] + beat_ofs;
      default: nxt_addr = addr_ff;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_ff <= ST_IDLE;
      cur_ch_ff <= 2'h0;
      beat_ff <= 2'h0;
      addr_ff <= 32'h00000000;
      ptr_data_ff <= 32'h00000000;
      hold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cur_ch_ff <= nxt_ch;
      beat_ff <= nxt_beat;
      addr_ff <= nxt_addr;
      if (state_ff == ST_PTR && I_BUS_ACK) ptr_data_ff <= I_BUS_RDATA;
      hold_ff <= unit_done ? tm_v[cur_ch_ff] : (state_ff != ST_IDLE && hold_ff);
    end
  end

  assign O_BUS_REQ = state_ff != ST_IDLE;
  assign O_BUS_WRITE = state_ff == ST_WR;
  assign O_BUS_ADDR = addr_ff;
  assign O_BUS_CH = cur_ch_ff;
  assign O_BUS_SIZE = (big_v[cur_ch_ff] || state_ff == ST_PTR) ? SIZE_LONG :
                      ctrl_ff[cur_ch_ff][B_TS+:2];
  assign O_BUS_HOLD = hold_ff || (O_BUS_REQ && tm_v[cur_ch_ff]);

  for (g = 0; g < EXT_CH; g++) begin : gack
    assign ack_act[g] = cur_ch_ff == g && ext_v[g] && (state_ff == ST_RD || state_ff == ST_WR) &&
                        (smd_v[g] || sdm_v[g] ||
                         (ctrl_ff[g][B_AM] ? state_ff == ST_WR : state_ff == ST_RD));
    assign O_HANDSHAKE_ACK_OUT[g] = ctrl_ff[g][B_AL] ? ack_act[g] : !ack_act[g];
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_last_unit;
    unit_done && cur_ch_ff == 2'h0 && cnt_ff[0] == CNT_ONE;
  endsequence

  chk_ack_phase: assert property (
    (state_ff == ST_WR && cur_ch_ff == 2'h0 && ctrl_ff[0][B_RS+:4] == RS_EXT_DUAL)
    |-> ack_act[0] == ctrl_ff[0][B_AM]) else $error("ack phase wrong");
  chk_ack_level: assert property (
    !O_BUS_REQ |-> O_HANDSHAKE_ACK_OUT == ~{ctrl_ff[1][B_AL], ctrl_ff[0][B_AL]})
    else $error("idle ack level wrong");
  chk_fields_zero: assert property (
    ctrl_ff[2][B_AL] == 1'b0 && ctrl_ff[3][B_AM] == 1'b0 && ctrl_ff[3][B_DS] == 1'b0)
    else $error("missing field not zero");
  chk_done_irq: assert property (
    s_last_unit ##1 1'b1 |-> te_ff[0] && O_END_IRQ[0] == ctrl_ff[0][B_IE])
    else $error("done flag or irq missing");
  chk_done_cause: assert property (
    $rose(te_ff[0]) |-> $past(unit_done) && $past(cur_ch_ff) == 2'h0)
    else $error("done flag without completion");
  chk_count_step: assert property (
    (done_v[0] && !wr_cnt[0]) |=> cnt_ff[0] == $past(cnt_ff[0]) - CNT_ONE)
    else $error("count not decremented");
  chk_abort_stop: assert property (
    (O_BUS_REQ && !en_vec[cur_ch_ff]) |=> !O_BUS_REQ) else $error("abort ignored");
  chk_start_gate: assert property (
    $rose(O_BUS_REQ) |-> $past(en_vec[nxt_ch])) else $error("start while disabled");
  chk_src_step: assert property (
    (done_v[0] && !wr_src[0] && !ptr_v[0] && ctrl_ff[0][B_SM+:2] == MODE_INC && big_v[0])
    |=> src_ff[0] == $past(src_ff[0]) + BLK_BYTES) else $error("source step wrong");
endmodule

// >>> rtl/dmach_pkg.sv
package dmach_pkg;
  localparam int NCH = 4;
  localparam int EXT_CH = 2;
  localparam int DI_CH = 3;
  localparam int CNT_W = 24;
  localparam int MOD_N = 6;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_DST = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL = 8'h40;
  localparam int CH_LSB = 4;
  localparam int REG_LSB = 2;
  localparam int B_DE = 0;
  localparam int B_TE = 1;
  localparam int B_IE = 2;
  localparam int B_TS = 3;
  localparam int B_TM = 5;
  localparam int B_DS = 6;
  localparam int B_RS = 8;
  localparam int B_SM = 12;
  localparam int B_DM = 14;
  localparam int B_AL = 16;
  localparam int B_AM = 17;
  localparam int B_DI = 20;
  localparam int G_DME = 0;
  localparam int G_NMI_HALT_FLAG = 1;
  localparam int G_AE = 2;
  localparam logic [31:0] MASK_EXT = 32'h0003FF7D;
  localparam logic [31:0] MASK_BASE = 32'h0000FF3D;
  localparam logic [31:0] MASK_DI = 32'h0010FF3D;
  localparam logic [3:0] RS_EXT_DUAL = 4'h0;
  localparam logic [3:0] RS_EXT_S_MD = 4'h2;
  localparam logic [3:0] RS_EXT_S_DM = 4'h3;
  localparam logic [3:0] RS_AUTO = 4'h4;
  localparam logic [3:0] RS_MOD_LO = 4'hA;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_16B = 2'h3;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [31:0] UNIT_BYTE = 32'h1;
  localparam logic [31:0] LW_BYTES = 32'h4;
  localparam logic [31:0] BLK_BYTES = 32'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_RD, ST_WR} xfer_st_t;
endpackage

// >>> rtl/dmach_step.sv
`timescale 1ns/1ps
module dmach_step import dmach_pkg::*; (
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_size,
  input wire logic i_ptr,
  output logic [31:0] o_next,
  output logic o_legal
);
  logic [31:0] mag;

  // pointer mode ignores unit size
  assign mag = i_ptr ? LW_BYTES : (i_size == SIZE_16B) ? BLK_BYTES : (UNIT_BYTE << i_size);
  assign o_next = (i_mode == MODE_INC) ? i_addr + mag :
                  (i_mode == MODE_DEC) ? i_addr - mag : i_addr;
  assign o_legal = (i_mode != MODE_BAD) &&
                   !(i_mode == MODE_DEC && i_size == SIZE_16B && !i_ptr);
endmodule

// >>> dv/dmach_partner.sv
`timescale 1ns/1ps
module dmach_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic i_slow,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [1:0] wait_ff;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    wait_ff = 2'h0;
  end
  // memory side: one-cycle ack, prompt or after wait states
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_ff == 2'h0 || !i_slow) begin
        o_ack <= 1'b1;
        o_rdata <= i_addr;
        wait_ff <= 2'h2;
      end else begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule

// >>> dv/dma_channel_control_tb.sv
`timescale 1ns/1ps
module dma_channel_control_tb import dmach_pkg::*;;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, bus_req, bus_wr, bus_ack, bus_hold, slow, nmi;
  logic [7:0] awaddr, araddr;
  logic [5:0] mod_n;
  logic [4:0] cs;
  logic [31:0] wdata, rdata, bus_addr, bus_rdata, src, dst, ctrl;
  logic [1:0] bresp, rresp, req_n, ack_out, bus_size, bus_ch;
  logic [3:0] irq;
  int errors, n_checks, s, b, step;
  logic [33:0] rd_q[$];
  logic [39:0] bus_q[$];

  dma_channel_control dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_AXI_AWADDR(awaddr),
    .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata),
    .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_HANDSHAKE_REQ_IN_N(req_n), .I_MOD_REQ_N(mod_n), .I_NMI(nmi), .I_ADDR_ERR(1'b0),
    .O_HANDSHAKE_ACK_OUT(ack_out), .O_END_IRQ(irq), .O_BUS_REQ(bus_req),
    .O_BUS_WRITE(bus_wr), .O_BUS_ADDR(bus_addr), .O_BUS_SIZE(bus_size), .O_BUS_CH(bus_ch),
    .O_BUS_HOLD(bus_hold), .I_BUS_ACK(bus_ack), .I_BUS_RDATA(bus_rdata));

  dmach_partner mem (.i_clk(clk), .i_req(bus_req), .i_addr(bus_addr), .i_slow(slow),
    .o_ack(bus_ack), .o_rdata(bus_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("reg got %h exp %h", got, exp));
  endtask
  task automatic cmp_bus(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("bus got %h exp %h", got, exp));
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) fail("pin level");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    rd_q.push_back({RESP_OK, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 50);
    bready <= 1'b0;
    if (t >= 50) begin
      fail("write hang");
      tally_and_finish();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    int t;
    rd_q.push_back(exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 50);
    rready <= 1'b0;
    if (t >= 50) begin
      fail("read hang");
      tally_and_finish();
    end
  endtask
  task automatic expect_bus(input logic [4:0] c, input logic w, input logic [1:0] ack,
                            input logic [31:0] a);
    bus_q.push_back({c, w, ack, a});
  endtask
  task automatic drain();
    int t;
    for (t = 0; t < 300 && bus_q.size() != 0; t++) @(posedge clk);
    if (bus_q.size() != 0) begin
      fail("bus hang");
      tally_and_finish();
    end
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each result
  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (rd_q.size() == 0) fail("stray response");
      else if (rvalid) cmp_rd({rresp, rdata}, rd_q.pop_front());
      else cmp_rd({bresp, 32'h0}, rd_q.pop_front());
    end
    if (bus_req && bus_ack) begin
      if (bus_q.size() == 0) fail("stray bus cycle");
      else cmp_bus({bus_hold, bus_ch, bus_size, bus_wr, ack_out, bus_addr}, bus_q.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, slow, nmi} = 8'h0;
    {awaddr, araddr, wdata} = 48'h0;
    req_n = 2'h3;
    mod_n = 6'h3F;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'h7977D60A));
    tick(12);
    rst_n <= 1'b1;
    axi_rd(OFS_CTRL, {RESP_OK, 32'h0});
    axi_rd(8'h44, {RESP_SLVERR, 32'h0});
    axi_wr(8'h20, 32'h00030040);
    axi_rd(8'h20, {RESP_OK, 32'h0});
    axi_wr(OFS_GLOBAL, 32'h1);
    // auto transfers over every unit size
    for (s = 0; s < 4; s++) begin
      src = ($urandom & 32'h0FFFFFF0) + 32'h100;
      dst = ($urandom & 32'h0FFFFFF0) + 32'h100;
      slow <= 1'($urandom);
      step = 1 << s;
      ctrl = (s == 3) ? 32'h5405 : 32'h9405;
      ctrl = ctrl | (s << 3) | ((s & 1) << 5);
      cs = {1'(s & 1), 2'h0, 2'((s == 3) ? 2 : s)};
      axi_wr(OFS_SRC, src);
      axi_wr(OFS_DST, dst);
      axi_wr(OFS_CNT, (s == 3) ? 32'h1 : 32'h2);
      for (b = 0; b < ((s == 3) ? 4 : 2); b++) begin
        expect_bus(cs, 1'b0, 2'h3, src + b * ((s == 3) ? 4 : step));
        expect_bus(cs, 1'b1, 2'h3, (s == 3) ? dst + 4 * b : dst - b * step);
      end
      axi_wr(OFS_CTRL, ctrl);
      drain();
      axi_rd(OFS_CTRL, {RESP_OK, ctrl | 32'h2});
      axi_rd(OFS_CNT, {RESP_OK, 32'h0});
      cmp_pin(irq[0], 1'b1);
      axi_wr(OFS_CTRL, ctrl & ~32'h3);
      axi_rd(OFS_CTRL, {RESP_OK, ctrl & ~32'h3});
      cmp_pin(irq[0], 1'b0);
    end
    // prohibited walk never starts
    axi_wr(OFS_CTRL, 32'h3405);
    tick(20);
    axi_wr(OFS_CTRL, 32'h0);
    // master enable off blocks auto start
    axi_wr(OFS_GLOBAL, 32'h0);
    axi_wr(OFS_CTRL, 32'h0405);
    tick(20);
    axi_wr(OFS_CTRL, 32'h0);
    axi_wr(OFS_GLOBAL, 32'h1);
    // ch1 external edge request, high-active ack in read cycle
    axi_wr(8'h18, src);
    axi_wr(8'h1C, dst);
    axi_wr(8'h14, 32'h1);
    axi_wr(8'h10, 32'h00010041);
    tick(2);
    cmp_pin(ack_out[1], 1'b0);
    tick(10);
    expect_bus(5'h04, 1'b0, 2'h3, src);
    expect_bus(5'h04, 1'b1, 2'h1, dst);
    req_n <= 2'h1;
    tick(3);
    req_n <= 2'h3;
    drain();
    axi_rd(8'h10, {RESP_OK, 32'h00010043});
    // ch0 external level request, low-active ack in write cycle
    axi_wr(OFS_SRC, src);
    axi_wr(OFS_DST, dst);
    axi_wr(OFS_CNT, 32'h1);
    expect_bus(5'h00, 1'b0, 2'h1, src);
    expect_bus(5'h00, 1'b1, 2'h0, dst);
    req_n <= 2'h2;
    axi_wr(OFS_CTRL, 32'h00020001);
    drain();
    req_n <= 2'h3;
    axi_rd(OFS_CTRL, {RESP_OK, 32'h00020003});
    axi_wr(OFS_CTRL, 32'h0);
    // ch2 on-chip module request on falling edge
    axi_wr(8'h28, src);
    axi_wr(8'h2C, dst);
    axi_wr(8'h24, 32'h1);
    expect_bus(5'h08, 1'b0, 2'h1, src);
    expect_bus(5'h08, 1'b1, 2'h1, dst);
    axi_wr(8'h20, 32'h00000A01);
    mod_n <= 6'h3E;
    tick(3);
    mod_n <= 6'h3F;
    drain();
    axi_rd(8'h20, {RESP_OK, 32'h00000A03});
    // nmi halts the channels
    nmi <= 1'b1;
    tick(1);
    nmi <= 1'b0;
    axi_rd(OFS_GLOBAL, {RESP_OK, 32'h3});
    axi_wr(OFS_CTRL, 32'h0405);
    tick(20);
    axi_rd(OFS_CTRL, {RESP_OK, 32'h0405});
    tally_and_finish();
  end
endmodule
